// ===== hdl/ser_cfg.svh
/*
 Constants of the status event reporting block: widths, bit positions and preset values.
 Assumes inclusion by bare name from the package and the design module.
*/
`ifndef SER_CFG_SVH
`define SER_CFG_SVH
`define SER_REG_W        16
`define SER_STB_W        8
`define SER_ESR_W        8
`define SER_STB_QUES_BIT 3
`define SER_STB_ESR_BIT  5
`define SER_STB_RQS_BIT  6
`define SER_STB_OPER_BIT 7
`define SER_QUES_LIM_BIT 9
`define SER_OPER_MEAS    4
`define SER_OPER_WTRG    5
`define SER_OPER_TRIG    6
`define SER_PTR_PRESET   16'hffff
`define SER_NTR_PRESET   16'h0000
`define SER_ZERO16       16'h0000
`endif

// ===== hdl/ser_pkg.sv
/*
 Types of the status event reporting block.
 Assumes the constants header is on the include path.
*/
`include "ser_cfg.svh"
package ser_pkg;
   // One status register group's software-written configuration.
   typedef struct packed
   {
      logic [`SER_REG_W-1:0] ptr;
      logic [`SER_REG_W-1:0] ntr;
      logic [`SER_REG_W-1:0] ena;
   } ser_cfg_s;

   // Which part a read strobe addresses.
   typedef enum logic [1:0]
   {
      SER_SEL_OPER = 2'h0,
      SER_SEL_QUES = 2'h1,
      SER_SEL_LIM  = 2'h3,
      SER_SEL_ESR  = 2'h2
   } ser_sel_e;
endpackage : ser_pkg

// ===== hdl/ser_status_event.sv
/*
 Status event reporting structure: operation, questionable and limit sub-register groups,
 each with condition, transition filters, clear-on-read event and enable parts, feeding
 the status byte and a service request; plus a clear-on-read standard event register.
 Assumes all inputs synchronous to core_clk_in; one read strobe per query.
*/
// Notes on behaviour
// - Condition reads return live source state and change nothing.
// - Event reads return latched bits then clear that event part.
// - Negative filter bit set: condition falling 1 to 0 sets event bit.
// - Positive filter bit set: condition rising 0 to 1 sets event bit.
// - Summary bit rises when an event bit and its enable are both one.
// - Questionable summary sits in status byte bit 3, enable value 8.
// - Status byte bit 6 is set while any status byte bit enabled for service request is one.
// - Limit violation summary occupies questionable bit 9, value 512.
// - Operation condition: running 16, awaiting trigger 32, triggered 64.
// - Standard event register query returns contents then clears all bits.
// - Preset: positive filters all one; negative filters, events, operation and questionable enables cleared; limit enable kept.
// - Operation enabled-event summary drives status byte bit 7.
`include "ser_cfg.svh"
module ser_status_event
   import ser_pkg::*;
#(
   parameter int W = `SER_REG_W
)
(
   input  wire logic                  core_clk_in,        // 10 MHz clock.
   input  wire logic                  rst_n_in,           // Async reset, active low.
   input  wire logic                  preset_in,          // Status preset pulse.
   input  wire logic                  acq_running_in,     // Acquisition running level.
   input  wire logic                  awaiting_trigger_in,// Waiting for trigger level.
   input  wire logic                  triggered_in,       // Triggered level.
   input  wire logic [W-1:0]          oper_other_in,      // Other operation condition bits.
   input  wire logic [W-1:0]          ques_cond_in,       // Questionable conditions.
   input  wire logic [W-1:0]          lim_cond_in,        // Per-measurement limit conditions.
   input  wire ser_cfg_s              oper_cfg_in,        // Operation filters and enable.
   input  wire ser_cfg_s              ques_cfg_in,        // Questionable filters and enable.
   input  wire ser_cfg_s              lim_cfg_in,         // Limit filters and enable.
   input  wire logic                  cfg_wr_in,          // Load the three configurations.
   input  wire logic [`SER_STB_W-1:0] srq_ena_in,         // Service request enable mask.
   input  wire logic [`SER_ESR_W-1:0] esr_set_in,         // Standard event set pulses.
   input  wire logic [`SER_ESR_W-1:0] esr_ena_in,         // Standard event enable mask.
   input  wire logic                  rd_cond_in,         // Condition read strobe.
   input  wire logic                  rd_event_in,        // Event read strobe.
   input  wire ser_sel_e              rd_sel_in,          // Part addressed by the read.
   output logic [W-1:0]               rd_data_out,        // Read data.
   output logic                       rd_valid_out,       // Read data valid pulse.
   output logic [`SER_STB_W-1:0]      stb_out,            // Status byte.
   output logic                       srq_out             // Service request pulse.
);

   ser_cfg_s        oper_cfg;
   ser_cfg_s        ques_cfg;
   ser_cfg_s        lim_cfg;
   logic [W-1:0]    oper_cond;
   logic [W-1:0]    oper_prev;
   logic [W-1:0]    oper_evt;
   logic [W-1:0]    lim_prev;
   logic [W-1:0]    lim_evt;
   logic [W-1:0]    ques_cond;
   logic [W-1:0]    ques_prev;
   logic [W-1:0]    ques_evt;
   logic [`SER_ESR_W-1:0] esr;
   logic            oper_sum;
   logic            ques_sum;
   logic            lim_sum;
   logic            esr_sum;
   logic            rqs_cond;
   logic            rqs_prev;
   logic [`SER_STB_W-1:0] next_stb;
   logic            rd_oper_evt;
   logic            rd_ques_evt;
   logic            rd_lim_evt;
   logic            rd_esr;

   // Transition filter: positive and negative edges that the filters pass.
   function automatic logic [W-1:0] edges(input logic [W-1:0] cur, input logic [W-1:0] prev,
                                          input logic [W-1:0] ptr, input logic [W-1:0] ntr);
      edges = (cur & ~prev & ptr) | (~cur & prev & ntr);
   endfunction : edges

   // Operation condition part mirrors the live acquisition states.
   always_comb
   begin
      oper_cond                 = oper_other_in;
      oper_cond[`SER_OPER_MEAS] = acq_running_in;
      oper_cond[`SER_OPER_WTRG] = awaiting_trigger_in;
      oper_cond[`SER_OPER_TRIG] = triggered_in;
   end

   // Summaries of enabled events; limit summary enters questionable bit 9.
   always_comb
   begin
      lim_sum  = |(lim_evt & lim_cfg.ena);
      oper_sum = |(oper_evt & oper_cfg.ena);
      ques_sum = |(ques_evt & ques_cfg.ena);
      esr_sum  = |(esr & esr_ena_in);
      ques_cond                    = ques_cond_in;
      ques_cond[`SER_QUES_LIM_BIT] = lim_sum;
   end

   // Read strobes that clear an event part; a condition read in the same cycle wins,
   // so its event bits are neither returned nor lost.
   always_comb
   begin
      rd_oper_evt = rd_event_in && !rd_cond_in && (rd_sel_in == SER_SEL_OPER);
      rd_ques_evt = rd_event_in && !rd_cond_in && (rd_sel_in == SER_SEL_QUES);
      rd_lim_evt  = rd_event_in && !rd_cond_in && (rd_sel_in == SER_SEL_LIM);
      rd_esr      = rd_event_in && !rd_cond_in && (rd_sel_in == SER_SEL_ESR);
   end

   // Status byte assembly and request condition.
   always_comb
   begin
      next_stb                      = '0;
      next_stb[`SER_STB_QUES_BIT]   = ques_sum;
      next_stb[`SER_STB_OPER_BIT]   = oper_sum;
      next_stb[`SER_STB_ESR_BIT]    = esr_sum;
      rqs_cond                      = |(next_stb & srq_ena_in);
      next_stb[`SER_STB_RQS_BIT]    = rqs_cond;
   end

   // Configuration registers; preset overrides a write.
   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         oper_cfg <= '{`SER_PTR_PRESET, `SER_NTR_PRESET, `SER_ZERO16};
         ques_cfg <= '{`SER_PTR_PRESET, `SER_NTR_PRESET, `SER_ZERO16};
         lim_cfg  <= '{`SER_PTR_PRESET, `SER_NTR_PRESET, `SER_ZERO16};
      end
      else if (preset_in)
      begin
         oper_cfg <= '{`SER_PTR_PRESET, `SER_NTR_PRESET, `SER_ZERO16};
         ques_cfg <= '{`SER_PTR_PRESET, `SER_NTR_PRESET, `SER_ZERO16};
         lim_cfg  <= '{`SER_PTR_PRESET, `SER_NTR_PRESET, lim_cfg.ena};
      end
      else if (cfg_wr_in)
      begin
         oper_cfg <= oper_cfg_in;
         ques_cfg <= ques_cfg_in;
         lim_cfg  <= lim_cfg_in;
      end
   end

   // Previous condition values for edge detection.
   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         oper_prev <= '0;
         ques_prev <= '0;
         lim_prev  <= '0;
      end
      else
      begin
         oper_prev <= oper_cond;
         ques_prev <= ques_cond;
         lim_prev  <= lim_cond_in;
      end
   end

   // Event parts: new edges win over a clearing read; preset clears.
   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         oper_evt <= '0;
         ques_evt <= '0;
         lim_evt  <= '0;
      end
      else if (preset_in)
      begin
         oper_evt <= '0;
         ques_evt <= '0;
         lim_evt  <= '0;
      end
      else
      begin
         // Bits hold until read, regardless of the condition returning.
         oper_evt <= (rd_oper_evt ? '0 : oper_evt)
                   | edges(oper_cond, oper_prev, oper_cfg.ptr, oper_cfg.ntr);
         ques_evt <= (rd_ques_evt ? '0 : ques_evt)
                   | edges(ques_cond, ques_prev, ques_cfg.ptr, ques_cfg.ntr);
         lim_evt  <= (rd_lim_evt ? '0 : lim_evt)
                   | edges(lim_cond_in, lim_prev, lim_cfg.ptr, lim_cfg.ntr);
      end
   end

   // Standard event register: query returns then clears, new sets survive.
   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         esr <= '0;
      else
         esr <= (rd_esr ? '0 : esr) | esr_set_in;
   end

   // Read port: condition reads are side-effect free.
   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         rd_data_out  <= '0;
         rd_valid_out <= 1'b0;
      end
      else
      begin
         rd_valid_out <= rd_cond_in | rd_event_in;
         rd_data_out  <= '0;
         if (rd_cond_in)
         begin
            unique case (rd_sel_in)
               SER_SEL_OPER: rd_data_out <= oper_cond;
               SER_SEL_QUES: rd_data_out <= ques_cond;
               SER_SEL_LIM:  rd_data_out <= lim_cond_in;
               SER_SEL_ESR:  rd_data_out <= {{(W-`SER_ESR_W){1'b0}}, esr};
            endcase
         end
         else if (rd_event_in)
         begin
            unique case (rd_sel_in)
               SER_SEL_OPER: rd_data_out <= oper_evt;
               SER_SEL_QUES: rd_data_out <= ques_evt;
               SER_SEL_LIM:  rd_data_out <= lim_evt;
               SER_SEL_ESR:  rd_data_out <= {{(W-`SER_ESR_W){1'b0}}, esr};
            endcase
         end
      end
   end

   // Status byte register and service request edge.
   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         stb_out  <= '0;
         rqs_prev <= 1'b0;
         srq_out  <= 1'b0;
      end
      else
      begin
         stb_out  <= next_stb;
         rqs_prev <= rqs_cond;
         srq_out  <= rqs_cond & ~rqs_prev;
      end
   end

   // Event read clears the part one cycle later unless a new edge arrives.
   a_evt_read_clr: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      rd_lim_evt && !preset_in && (edges(lim_cond_in, lim_prev, lim_cfg.ptr, lim_cfg.ntr) == '0)
      |=> lim_evt == '0)
      else $error("limit event part not cleared by read");
   a_cond_read_keep: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      rd_cond_in && !preset_in |=> (lim_evt & $past(lim_evt)) == $past(lim_evt))
      else $error("condition read disturbed event part");
   a_pos_edge_set: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      !preset_in && lim_cond_in[0] && !lim_prev[0] && lim_cfg.ptr[0] |=> lim_evt[0])
      else $error("rising edge not latched");
   a_neg_edge_set: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      !preset_in && !lim_cond_in[0] && lim_prev[0] && lim_cfg.ntr[0] |=> lim_evt[0])
      else $error("falling edge not latched");
   a_evt_sticky: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      oper_evt[0] && !rd_oper_evt && !preset_in |=> oper_evt[0])
      else $error("event bit lost without read");
   a_lim_to_stb: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      lim_sum && ques_cfg.ptr[`SER_QUES_LIM_BIT] && ques_cfg.ena[`SER_QUES_LIM_BIT]
      && !ques_prev[`SER_QUES_LIM_BIT] && !preset_in && !cfg_wr_in
      ##1 !rd_ques_evt && !preset_in |=> stb_out[`SER_STB_QUES_BIT])
      else $error("limit summary did not reach status byte");
   a_oper_sum_bit: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      oper_sum |=> stb_out[`SER_STB_OPER_BIT])
      else $error("operation summary missing from bit 7");
   a_rqs_bit: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      ((ques_sum && srq_ena_in[`SER_STB_QUES_BIT]) || (oper_sum && srq_ena_in[`SER_STB_OPER_BIT])
      || (esr_sum && srq_ena_in[`SER_STB_ESR_BIT])) && !stb_out[`SER_STB_RQS_BIT]
      |=> srq_out && stb_out[`SER_STB_RQS_BIT])
      else $error("request not issued with bit 6");
   a_oper_weights: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      rd_cond_in && rd_sel_in == SER_SEL_OPER |=> rd_data_out[6:4]
      == $past({triggered_in, awaiting_trigger_in, acq_running_in}))
      else $error("operation weights wrong");
   a_esr_clear: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      rd_esr && esr_set_in == '0 |=> esr == '0)
      else $error("event status register not cleared");
   a_preset_cfg: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      preset_in |=> ques_cfg.ptr == `SER_PTR_PRESET && ques_cfg.ena == '0 && ques_evt == '0)
      else $error("preset values wrong");

endmodule : ser_status_event

// ===== dv/ser_status_event_tb.sv
/*
 Self-checking bench of the status event reporting block, with a cycle model of it.
 Assumes the package and the block under hdl/ are compiled first.
*/
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   import ser_pkg::*;
   localparam logic [2:0] OPS [4] = '{3'b001, 3'b011, 3'b111, 3'b110};
   logic        core_clk_in = 1'b0;
   logic        rst_n_in = 1'b0;
   logic        preset_in, acq_running_in, awaiting_trigger_in, triggered_in, cfg_wr_in;
   logic        rd_cond_in, rd_event_in, rd_valid_out, srq_out;
   logic [15:0] oper_other_in, ques_cond_in, lim_cond_in, rd_data_out;
   ser_cfg_s    oper_cfg_in, ques_cfg_in, lim_cfg_in;
   logic [7:0]  srq_ena_in, esr_set_in, esr_ena_in, stb_out;
   ser_sel_e    rd_sel_in;
   logic [15:0] m_p[3], m_n[3], m_e[3], m_prv[3], m_evt[3], m_cnd[3], m_rd, m_edg;
   logic [7:0]  m_esr, m_stb, m_nstb;
   logic        m_vld, m_srq;
   int          err_total, num_checks, cyc, g;

   // Block under test.
   ser_status_event u_ser_status_event (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
      .preset_in(preset_in), .acq_running_in(acq_running_in),
      .awaiting_trigger_in(awaiting_trigger_in), .triggered_in(triggered_in),
      .oper_other_in(oper_other_in), .ques_cond_in(ques_cond_in), .lim_cond_in(lim_cond_in),
      .oper_cfg_in(oper_cfg_in), .ques_cfg_in(ques_cfg_in), .lim_cfg_in(lim_cfg_in),
      .cfg_wr_in(cfg_wr_in), .srq_ena_in(srq_ena_in), .esr_set_in(esr_set_in),
      .esr_ena_in(esr_ena_in), .rd_cond_in(rd_cond_in), .rd_event_in(rd_event_in),
      .rd_sel_in(rd_sel_in), .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out),
      .stb_out(stb_out), .srq_out(srq_out));

   // Clock of 100 ns period.
   always #50 core_clk_in = ~core_clk_in;

   // Compares one value and counts the outcome.
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      num_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   // Prints the verdict and ends the run.
   task automatic conclude();
      if (err_total == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : conclude

   // Waits one edge, then drops every pulse input just after it.
   task automatic tick();
      @(posedge core_clk_in);
      #2;
      {preset_in, cfg_wr_in, rd_cond_in, rd_event_in, esr_set_in} = '0;
   endtask : tick

   // Settles the conditions, empties the standard event register, then presets.
   task automatic do_preset();
      repeat (3) tick();
      rd_event_in = 1'b1;
      rd_sel_in = SER_SEL_ESR;
      tick();
      preset_in = 1'b1;
      cfg_wr_in = 1'b1;
      tick();
   endtask : do_preset

   // Reference model: updates once per edge, then compares every output.
   always @(posedge core_clk_in)
   begin
      m_cnd[0] = oper_other_in;
      m_cnd[0][6:4] = {triggered_in, awaiting_trigger_in, acq_running_in};
      m_cnd[1] = ques_cond_in;
      m_cnd[1][9] = |(m_evt[2] & m_e[2]);
      m_cnd[2] = lim_cond_in;
      g = (rd_sel_in == SER_SEL_OPER) ? 0 : (rd_sel_in == SER_SEL_QUES) ? 1 :
          (rd_sel_in == SER_SEL_LIM) ? 2 : 3;
      if (!rst_n_in)
      begin
         for (int i = 0; i < 3; i++)
            {m_p[i], m_n[i], m_e[i], m_prv[i], m_evt[i]} = {16'hffff, 64'h0};
         {m_esr, m_stb, m_srq, m_vld, m_rd} = '0;
      end
      else
      begin
         m_vld = rd_cond_in | rd_event_in;
         m_rd = rd_cond_in ? ((g == 3) ? {8'h00, m_esr} : m_cnd[g]) : !rd_event_in ? 16'h0000 :
                (g == 3) ? {8'h00, m_esr} : m_evt[g];
         m_nstb = {|(m_evt[0] & m_e[0]), 1'b0, |(m_esr & esr_ena_in), 1'b0,
                   |(m_evt[1] & m_e[1]), 3'b000};
         m_nstb[6] = |(m_nstb & srq_ena_in);
         m_srq = m_nstb[6] & !m_stb[6];
         m_stb = m_nstb;
         for (int i = 0; i < 3; i++)
         begin
            m_edg = (m_p[i] & m_cnd[i] & ~m_prv[i]) | (m_n[i] & ~m_cnd[i] & m_prv[i]);
            m_evt[i] = preset_in ? 16'h0000 : (rd_event_in && !rd_cond_in && g == i) ? m_edg :
                       m_evt[i] | m_edg;
            m_prv[i] = m_cnd[i];
         end
         m_esr = (rd_event_in && !rd_cond_in && g == 3) ? esr_set_in : m_esr | esr_set_in;
         if (preset_in)
            {m_p[0], m_p[1], m_p[2], m_n[0], m_n[1], m_n[2], m_e[0], m_e[1]} =
               {48'hffffffffffff, 80'h0};
         else if (cfg_wr_in)
            {m_p[0], m_n[0], m_e[0], m_p[1], m_n[1], m_e[1], m_p[2], m_n[2], m_e[2]} =
               {oper_cfg_in, ques_cfg_in, lim_cfg_in};
      end
      #1;
      chk(rd_data_out, m_rd, "read data");
      chk(rd_valid_out, m_vld, "read valid");
      chk(stb_out, m_stb, "status byte");
      chk(srq_out, m_srq, "service request");
   end

   // Cuts a hang short.
   always @(posedge core_clk_in)
   begin
      cyc++;
      if (cyc == 10000)
      begin
         err_total++;
         conclude();
      end
   end

   // Main sequence: limit walk, operation weights, then random traffic with presets.
   initial
   begin
      void'($urandom(32'h6e3170ad));
      {preset_in, acq_running_in, awaiting_trigger_in, triggered_in, cfg_wr_in} = '0;
      {rd_cond_in, rd_event_in, oper_other_in, ques_cond_in, lim_cond_in} = '0;
      {oper_cfg_in, ques_cfg_in, lim_cfg_in, srq_ena_in, esr_set_in, esr_ena_in} = '0;
      rd_sel_in = SER_SEL_OPER;
      repeat (8) @(posedge core_clk_in);
      #2;
      rst_n_in = 1'b1;
      tick();
      lim_cfg_in = {16'hffff, 16'h0000, 16'hffff};
      ques_cfg_in = {16'hffff, 16'h0000, 16'h0200};
      oper_cfg_in = {16'hffff, 16'h0000, 16'h0000};
      cfg_wr_in = 1'b1;
      srq_ena_in = 8'h08;
      tick();
      lim_cond_in[0] = 1'b1;
      repeat (3) @(posedge core_clk_in);
      #1;
      chk(stb_out, 8'h48, "status byte after limit");
      chk(srq_out, 1'b1, "request pulse");
      tick();
      rd_event_in = 1'b1;
      rd_sel_in = SER_SEL_QUES;
      for (int k = 0; k < 4; k++)
      begin
         tick();
         {triggered_in, awaiting_trigger_in, acq_running_in} = OPS[k];
         rd_cond_in = 1'b1;
         rd_sel_in = SER_SEL_OPER;
         tick();
         chk(rd_data_out, {9'h0, OPS[k], 4'h0}, "operation condition");
      end
      for (int n = 0; n < 4000; n++)
      begin
         tick();
         if (n % 500 == 499)
            do_preset();
         lim_cond_in[$urandom_range(15)] ^= ($urandom_range(3) == 0);
         ques_cond_in[$urandom_range(15)] ^= ($urandom_range(3) == 0);
         oper_other_in[$urandom_range(15)] ^= ($urandom_range(3) == 0);
         if ($urandom_range(7) == 0)
            {triggered_in, awaiting_trigger_in, acq_running_in} = 3'($urandom);
         oper_cfg_in = ser_cfg_s'(48'({$urandom, $urandom}));
         ques_cfg_in = ser_cfg_s'(48'({$urandom, $urandom}));
         lim_cfg_in = ser_cfg_s'(48'({$urandom, $urandom}));
         cfg_wr_in = ($urandom_range(31) == 0);
         srq_ena_in = ($urandom_range(63) == 0) ? 8'($urandom) : srq_ena_in;
         esr_ena_in = ($urandom_range(63) == 0) ? 8'($urandom) : esr_ena_in;
         esr_set_in = ($urandom_range(15) == 0) ? 8'($urandom) : 8'h00;
         rd_cond_in = ($urandom_range(5) == 0);
         rd_event_in = ($urandom_range(3) == 0);
         rd_sel_in = ser_sel_e'($urandom_range(3));
      end
      repeat (4) tick();
      conclude();
   end
endmodule : testbench
